// ---- shared/bpio_pkg.sv ----
// constants for the parallel i/o control block
// assumes a single 200 MHz clock and no software-visible registers
//
// Operation
// - serial link up to 115200 baud, full commands
// - two-character unit address, sixteen units max
// - serial active until bus goes remote
// - bus handshake, talker, listener, srq, clear, trigger
// - two primaries or primary plus secondaries 00/01
// - srq only untalked, enabled, event or questionable bit pending
// - monitored input changes feed questionable status
// - inhibit within 1 us of ready edge
// - six characters load about 0.15 ms after talk
// - output appears 0.6 to 5.3 ms after terminator
// - pulse width 10..30000 ms, 10 ms steps, 50 default
// - strobe, trigger, clear pulses at least 5 us
// - reset pulse 40 us, held 70 ms reset period; the command pulse also lasts the 70 ms hold
// - indicators: power, ready, talk, listen, srq
// - error indicator lights on bad command
// - lock hides setup and rejects setup changes
// - 48 data lines plus 2 status inputs
package bpio_pkg;
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned CLK_NS          = 5;
  localparam int unsigned MAX_BAUD        = 115_200;
  localparam int unsigned DATA_LINES      = 48;
  localparam int unsigned STATUS_LINES    = 2;
  localparam int unsigned MAX_UNITS       = 16;
  localparam int unsigned MAX_PRIMARY     = 30;
  localparam logic [4:0]  SECONDARY_LOW   = 5'h00;
  localparam logic [4:0]  SECONDARY_HIGH  = 5'h01;
  // times in their own units
  localparam int unsigned STROBE_US       = 5;
  localparam int unsigned RESET_PULSE_US  = 40;
  localparam int unsigned RESET_HOLD_MS   = 70;
  localparam int unsigned INHIBIT_MAX_US  = 1;
  localparam int unsigned OUT_MIN_US      = 600;
  localparam int unsigned OUT_MAX_US      = 5300;
  localparam int unsigned STEP_MS         = 10;
  localparam int unsigned WIDTH_MIN_STEPS = 1;
  localparam int unsigned WIDTH_MAX_STEPS = 3000;
  localparam logic [11:0] WIDTH_DEF_STEPS = 12'h005;
  // derived cycle counts, cycles per us rounded down
  localparam int unsigned CYC_PER_US      = 1000 / CLK_NS;
  localparam int unsigned STROBE_CYC      = STROBE_US * CYC_PER_US;
  localparam int unsigned RESET_PULSE_CYC = RESET_PULSE_US * CYC_PER_US;
  localparam int unsigned INHIBIT_MAX_CYC = INHIBIT_MAX_US * CYC_PER_US;
  localparam int unsigned OUT_MIN_CYC     = OUT_MIN_US * CYC_PER_US;
  localparam int unsigned RESET_HOLD_CYC  = RESET_HOLD_MS * 1000 * CYC_PER_US;
  localparam int unsigned STEP_CYC        = STEP_MS * 1000 * CYC_PER_US;
  // address modes
  typedef enum logic [1:0] {
    BPIO_ADDR_SINGLE = 2'b00,
    BPIO_ADDR_DUAL   = 2'b01,
    BPIO_ADDR_SEC    = 2'b10
  } bpio_addr_e;
endpackage

// ---- rtl/bpio_ctrl.sv ----
// parallel i/o control core: interface select, addressing, srq, pulses
// assumes command decode lives in a sequencer that gives one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module bpio_ctrl #(
  parameter int unsigned STEP_CYC       = bpio_pkg::STEP_CYC,
  parameter int unsigned RESET_HOLD_CYC = bpio_pkg::RESET_HOLD_CYC,
  parameter int unsigned OUT_MIN_CYC    = bpio_pkg::OUT_MIN_CYC,
  parameter int unsigned MON_LINES      = 15
) (
  // clock and reset
  input  wire logic                            mclk,
  input  wire logic                            rstn,
  // host interface state
  input  wire logic                            serial_present,
  input  wire logic                            bus_present,
  input  wire logic                            bus_remote,
  input  wire logic                            serial_cmd_valid,
  input  wire logic [7:0]                      serial_unit_addr,
  input  wire logic [3:0]                      my_unit_addr,
  input  wire logic                            bus_cmd_valid,
  output logic                                 cmd_accept,
  output logic                                 serial_selected,
  // bus addressing
  input  wire logic [4:0]                      primary_addr,
  input  wire bpio_pkg::bpio_addr_e            addr_mode,
  input  wire logic [4:0]                      rx_primary,
  input  wire logic                            rx_sec_valid,
  input  wire logic [4:0]                      rx_secondary,
  output logic                                 addr_match,
  output logic                                 addr_upper,
  // command events from sequencer
  input  wire logic                            cmd_strobe,
  input  wire logic                            cmd_trigger,
  input  wire logic                            cmd_clear,
  input  wire logic                            cmd_reset,
  input  wire logic                            cmd_pulse,
  input  wire logic                            cmd_terminator,
  input  wire logic                            cmd_error,
  input  wire logic                            cmd_setup_write,
  input  wire logic [11:0]                     pulse_steps,
  input  wire logic                            pulse_width_write,
  input  wire logic                            lock_on,
  output logic                                 setup_reject,
  output logic                                 setup_visible,
  // status and srq
  input  wire logic                            talker,
  input  wire logic                            listener,
  input  wire logic                            srq_enable,
  input  wire logic                            event_status_pending,
  input  wire logic                            self_test_ok,
  input  wire logic [MON_LINES-1:0]            monitor_in,
  input  wire logic [MON_LINES-1:0]            monitor_mask,
  input  wire logic                            questionable_clear,
  output logic [MON_LINES-1:0]                 questionable_reg,
  output logic                                 srq_out,
  // parallel port
  input  wire logic                            external_data_ready,
  input  wire logic [bpio_pkg::DATA_LINES-1:0] data_in,
  input  wire logic [bpio_pkg::STATUS_LINES-1:0] status_in,
  input  wire logic [bpio_pkg::DATA_LINES-1:0] out_word,
  output logic [bpio_pkg::DATA_LINES-1:0]      data_out,
  output logic [bpio_pkg::DATA_LINES-1:0]      input_latch,
  output logic [bpio_pkg::STATUS_LINES-1:0]    status_sync,
  output logic                                 data_inhibit,
  output logic                                 strobe_out,
  output logic                                 trigger_out,
  output logic                                 clear_out,
  output logic                                 reset_out,
  output logic                                 pulse_out,
  // indicators
  output logic                                 power_indicator,
  output logic                                 ready_indicator,
  output logic                                 talk_indicator,
  output logic                                 listen_indicator,
  output logic                                 srq_indicator,
  output logic                                 error_indicator
);
  localparam int unsigned SW = 16;
  localparam int unsigned LW = 24;
  localparam logic [SW-1:0] STB_END  = SW'(bpio_pkg::STROBE_CYC - 1);
  localparam logic [LW-1:0] RST_HOLD = LW'(RESET_HOLD_CYC - 1);
  localparam logic [LW-1:0] OUT_END  = LW'(OUT_MIN_CYC - 1);
  localparam logic [LW-1:0] STEP_END = LW'(STEP_CYC - 1);

  // parameter checks: refuse monitor widths and counts that the timers cannot serve
  if (MON_LINES < 1 || MON_LINES > 15) begin : g_bad_mon
    $error("MON_LINES out of range");
  end
  if (STEP_CYC < 1 || OUT_MIN_CYC < 1) begin : g_bad_count
    $error("step or out count below one");
  end
  if (RESET_HOLD_CYC <= bpio_pkg::RESET_PULSE_CYC) begin : g_bad_hold
    $error("reset hold too short");
  end
  if (RESET_HOLD_CYC > (1 << LW) || STEP_CYC > (1 << LW) || OUT_MIN_CYC > (1 << LW)) begin : g_bad_long
    $error("count too wide for timers");
  end
  if (bpio_pkg::STROBE_CYC > (1 << SW)) begin : g_bad_strobe
    $error("strobe count too wide");
  end

  // input synchronisers: two flops before any logic
  logic [MON_LINES+bpio_pkg::STATUS_LINES:0] sync1_reg, sync2_reg;
  logic [bpio_pkg::DATA_LINES-1:0]           din1_reg, din2_reg;
  always_ff @(posedge mclk) begin
    sync1_reg <= {external_data_ready, status_in, monitor_in};
    sync2_reg <= sync1_reg;
    din1_reg  <= data_in;
    din2_reg  <= din1_reg;
  end
  wire                  edr_s  = sync2_reg[MON_LINES+bpio_pkg::STATUS_LINES];
  wire [MON_LINES-1:0]  mon_s  = sync2_reg[MON_LINES-1:0];
  assign status_sync = sync2_reg[MON_LINES+:bpio_pkg::STATUS_LINES];

  // interface select: serial until bus goes remote, then bus
  // the bus never hands control back; only a reset returns it to serial
  logic bus_owns_reg;
  always_ff @(posedge mclk) begin
    if (!rstn) bus_owns_reg <= 1'b0;
    else if (bus_present && bus_remote) bus_owns_reg <= 1'b1;
  end
  wire serial_owns = serial_present && !(bus_owns_reg || !serial_present);
  // two character unit address, low nibble picks one of sixteen units
  wire serial_addr_ok = (serial_unit_addr[3:0] == my_unit_addr);
  assign serial_selected = serial_owns;
  assign cmd_accept = serial_owns ? (serial_cmd_valid && serial_addr_ok)
                                  : (bus_cmd_valid && bus_present);

  // bus address decode
  wire prim_ok  = (primary_addr <= 5'(bpio_pkg::MAX_PRIMARY));
  wire hit_lo   = prim_ok && (rx_primary == primary_addr);
  wire hit_hi   = prim_ok && (rx_primary == primary_addr + 5'h01);
  wire sec_lo   = rx_sec_valid && (rx_secondary == bpio_pkg::SECONDARY_LOW);
  wire sec_hi   = rx_sec_valid && (rx_secondary == bpio_pkg::SECONDARY_HIGH);
  assign addr_match = (addr_mode == bpio_pkg::BPIO_ADDR_SINGLE) ? hit_lo :
                      (addr_mode == bpio_pkg::BPIO_ADDR_DUAL)   ? (hit_lo || hit_hi) :
                      (hit_lo && (sec_lo || sec_hi));
  assign addr_upper = (addr_mode == bpio_pkg::BPIO_ADDR_DUAL) ? hit_hi :
                      (addr_mode == bpio_pkg::BPIO_ADDR_SEC)  ? (hit_lo && sec_hi) : 1'b0;

  // questionable status: sticky change bits, set wins over clear
  // previous value follows the pins in reset, so idle-high lines raise no false change
  logic [MON_LINES-1:0] mon_prev_reg;
  wire  [MON_LINES-1:0] mon_change = (mon_s ^ mon_prev_reg) & monitor_mask;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mon_prev_reg     <= mon_s;
      questionable_reg <= '0;
    end else begin
      mon_prev_reg     <= mon_s;
      questionable_reg <= (questionable_clear ? '0 : questionable_reg) | mon_change;
    end
  end

  // service request, dropped while addressed as talker
  // the request drops the cycle after the unit is addressed to talk
  wire srq_next = !talker && srq_enable && (event_status_pending || (|questionable_reg));
  always_ff @(posedge mclk) begin
    if (!rstn) srq_out <= 1'b0;
    else       srq_out <= srq_next;
  end

  // lock handling for stored setup
  assign setup_reject  = lock_on && cmd_setup_write;
  assign setup_visible = !lock_on;

  // pulse width register in 10 ms steps
  // out-of-range or locked writes are dropped; flagging them is the sequencer's job
  logic [11:0] width_reg;
  wire width_ok = (pulse_steps >= 12'(bpio_pkg::WIDTH_MIN_STEPS)) &&
                  (pulse_steps <= 12'(bpio_pkg::WIDTH_MAX_STEPS));
  always_ff @(posedge mclk) begin
    if (!rstn) width_reg <= bpio_pkg::WIDTH_DEF_STEPS;
    else if (pulse_width_write && width_ok && !lock_on) width_reg <= pulse_steps;
  end

  // short control pulses have one timing counter each via generate
  // a new start while running restarts the count and stretches the pulse
  localparam int unsigned NP = 3;
  wire [NP-1:0] p_start = {cmd_clear, cmd_trigger, cmd_strobe};
  logic [NP-1:0] p_act;
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pulse
      logic [SW-1:0] cnt_reg;
      logic          on_reg;
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          on_reg  <= 1'b0;
          cnt_reg <= '0;
        end else if (p_start[gi]) begin
          on_reg  <= 1'b1;
          cnt_reg <= '0;
        end else if (on_reg) begin
          on_reg  <= (cnt_reg != STB_END);
          cnt_reg <= cnt_reg + SW'(1);
        end
      end
      assign p_act[gi] = on_reg;
    end
  endgenerate
  assign strobe_out  = p_act[0];
  assign trigger_out = p_act[1];
  assign clear_out   = p_act[2];

  // reset output held for the whole internal reset period
  // the command pulse uses the same hold, far above the 40 us least width
  logic [LW-1:0] rst_cnt_reg;
  logic          rst_on_reg;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rst_on_reg  <= 1'b1;
      rst_cnt_reg <= '0;
    end else if (cmd_reset) begin
      rst_on_reg  <= 1'b1;
      rst_cnt_reg <= '0;
    end else if (rst_on_reg) begin
      rst_on_reg  <= (rst_cnt_reg != RST_HOLD);
      rst_cnt_reg <= rst_cnt_reg + LW'(1);
    end
  end
  assign reset_out = rst_on_reg;

  // programmable line pulse: step tick and step count
  // width is taken at start, so a write during a pulse affects the next one
  logic [LW-1:0] step_cnt_reg;
  logic [11:0]   steps_left_reg;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pulse_out      <= 1'b0;
      step_cnt_reg   <= '0;
      steps_left_reg <= '0;
    end else if (cmd_pulse) begin
      pulse_out      <= 1'b1;
      step_cnt_reg   <= '0;
      steps_left_reg <= width_reg;
    end else if (pulse_out) begin
      step_cnt_reg <= (step_cnt_reg == STEP_END) ? '0 : step_cnt_reg + LW'(1);
      if (step_cnt_reg == STEP_END) begin
        steps_left_reg <= steps_left_reg - 12'h001;
        pulse_out      <= (steps_left_reg != 12'h001);
      end
    end
  end

  // output latency: data lands a fixed 0.6 ms after terminator
  // a terminator while waiting replaces the pending word and restarts the wait
  logic [LW-1:0] out_cnt_reg;
  logic          out_wait_reg;
  logic [bpio_pkg::DATA_LINES-1:0] pend_reg;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      out_wait_reg <= 1'b0;
      out_cnt_reg  <= '0;
      pend_reg     <= '0;
      data_out     <= '0;
    end else if (cmd_terminator) begin
      out_wait_reg <= 1'b1;
      out_cnt_reg  <= '0;
      pend_reg     <= out_word;
    end else if (out_wait_reg) begin
      out_cnt_reg <= out_cnt_reg + LW'(1);
      if (out_cnt_reg == OUT_END) begin
        data_out     <= pend_reg;
        out_wait_reg <= 1'b0;
      end
    end
  end

  // data inhibit: set on ready rising edge, clear once loaded by talker
  // the word comes from its own two-flop pair and must be steady by the edge
  logic edr_prev_reg;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      edr_prev_reg <= edr_s; // no false edge after reset
      data_inhibit <= 1'b0;
      input_latch  <= '0;
    end else begin
      edr_prev_reg <= edr_s;
      if (edr_s && !edr_prev_reg) begin
        data_inhibit <= 1'b1;
        input_latch  <= din2_reg;
      end else if (data_inhibit && talker) begin
        data_inhibit <= 1'b0;
      end
    end
  end

  // front panel indicators
  logic err_reg;
  always_ff @(posedge mclk) begin
    if (!rstn) err_reg <= 1'b0;
    else if (cmd_error) err_reg <= 1'b1;
    else if (cmd_clear) err_reg <= 1'b0;
  end
  assign power_indicator  = 1'b1;
  assign ready_indicator  = self_test_ok && !rst_on_reg;
  assign talk_indicator   = talker;
  assign listen_indicator = listener;
  assign srq_indicator    = srq_out;
  assign error_indicator  = err_reg;
endmodule
`default_nettype wire

// ---- dv/bpio_ctrl_assertions.sv ----
// concurrent checks on the parallel i/o control core
// assumes it is bound into bpio_ctrl and watches only that module's ports
`timescale 1ns/1ps
`default_nettype none
module bpio_ctrl_assertions (
  // clock, reset and command inputs
  input wire logic       mclk, rstn, cmd_strobe, cmd_trigger, cmd_clear, cmd_reset, cmd_error,
  input wire logic       cmd_setup_write, lock_on, talker, listener, srq_enable, bus_remote, bus_present,
  input wire logic       serial_cmd_valid, bus_cmd_valid, external_data_ready,
  input wire logic [7:0] serial_unit_addr,
  input wire logic [3:0] my_unit_addr,
  input wire logic [4:0] primary_addr,
  // outputs under watch
  input wire logic       setup_reject, setup_visible, strobe_out, trigger_out, clear_out, reset_out,
  input wire logic       srq_out, error_indicator, serial_selected, cmd_accept, addr_match,
  input wire logic       power_indicator, talk_indicator, listen_indicator, data_inhibit
);
  int unsigned strobe_run;
  // length of the running strobe pulse, so its width can be judged at the falling edge
  always_ff @(posedge mclk) begin
    strobe_run <= (!rstn || !strobe_out) ? 0 : strobe_run + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_strobe_start: assert property (cmd_strobe |=> strobe_out)
    else $error("strobe did not follow its command");
  a_strobe_width: assert property ($fell(strobe_out) |-> strobe_run >= bpio_pkg::STROBE_CYC)
    else $error("strobe pulse too short");
  a_trig_clear: assert property ((cmd_trigger |=> trigger_out) and (cmd_clear |=> clear_out))
    else $error("trigger or clear pulse missing");
  a_reset_cmd: assert property (cmd_reset |=> reset_out [*8])
    else $error("reset pulse too short");
  a_reset_hold: assert property ($rose(rstn) |-> reset_out)
    else $error("reset output low right after reset");
  a_srq_gate: assert property ((talker || !srq_enable) |=> !srq_out)
    else $error("service request while talker or disabled");
  a_error_light: assert property ((cmd_error && !cmd_clear) |=> error_indicator)
    else $error("error indicator stayed dark");
  a_lock_guard: assert property (setup_reject == (lock_on && cmd_setup_write) && setup_visible == !lock_on)
    else $error("lock handling wrong");
  a_bus_takes: assert property ((bus_present && bus_remote) |=> !serial_selected)
    else $error("serial still selected after remote");
  a_cmd_route: assert property (cmd_accept == (serial_selected ?
      (serial_cmd_valid && serial_unit_addr[3:0] == my_unit_addr) : (bus_cmd_valid && bus_present)))
    else $error("command routed wrongly");
  a_addr_range: assert property (primary_addr > 5'h1e |-> !addr_match)
    else $error("primary address above range matched");
  a_indicators: assert property (power_indicator && talk_indicator == talker && listen_indicator == listener)
    else $error("indicator wrong");
  a_inhibit_fast: assert property ($rose(external_data_ready) && !talker |-> ##[1:200] data_inhibit)
    else $error("inhibit too late");
endmodule
bind bpio_ctrl bpio_ctrl_assertions bpio_ctrl_assertions_i (.*);
`default_nettype wire

// ---- dv/bpio_device_model.sv ----
// parallel device on the data side of the port
// assumes the bench raises present while a word is offered
`timescale 1ns/1ps
`default_nettype none
module bpio_device_model (
  // clock and offer
  input  wire logic        mclk,
  input  wire logic        present,
  input  wire logic [47:0] word,
  // port pins
  output logic             external_data_ready,
  output logic [47:0]      data_in,
  output logic [1:0]       status_in
);
  initial begin
    external_data_ready = 1'b0;
    data_in = '1;
    status_in = 2'h3;
  end
  // data settles a cycle before the ready edge; released lines float to the pull-up level
  always @(posedge mclk) begin
    data_in <= present ? word : '1;
    status_in <= present ? word[1:0] : 2'h3;
    external_data_ready <= present && data_in == word;
  end
endmodule
`default_nettype wire

// ---- dv/bpio_ctrl_bench.sv ----
// self-checking bench for the parallel i/o control core
// assumes bpio_pkg, the core, the device model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module bpio_ctrl_bench;
  localparam int unsigned STEP = 10;
  localparam int unsigned HOLD = 8200;
  localparam int unsigned OUTC = 20;
  logic mclk, rstn, serial_present, bus_present, bus_remote, serial_cmd_valid, bus_cmd_valid, rx_sec_valid;
  logic cmd_terminator, cmd_error, cmd_setup_write, pulse_width_write, lock_on, talker, listener, present;
  logic srq_enable, event_status_pending, self_test_ok, questionable_clear, external_data_ready;
  logic [7:0] serial_unit_addr;
  logic [3:0] my_unit_addr;
  logic [4:0] primary_addr, rx_primary, rx_secondary, cmdv;
  logic [11:0] pulse_steps;
  logic [14:0] monitor_in, monitor_mask, questionable_reg;
  logic [47:0] out_word, word, data_in, data_out, input_latch;
  logic [1:0] status_in, status_sync;
  bpio_pkg::bpio_addr_e addr_mode;
  logic cmd_accept, serial_selected, addr_match, addr_upper, setup_reject, setup_visible, srq_out, data_inhibit;
  logic strobe_out, trigger_out, clear_out, reset_out, pulse_out, power_indicator, ready_indicator;
  logic talk_indicator, listen_indicator, srq_indicator, error_indicator;
  // command strobes fanned out from one vector
  wire logic cmd_strobe = cmdv[0];
  wire logic cmd_trigger = cmdv[1];
  wire logic cmd_clear = cmdv[2];
  wire logic cmd_reset = cmdv[3];
  wire logic cmd_pulse = cmdv[4];
  wire logic [4:0] outs = {pulse_out, reset_out, clear_out, trigger_out, strobe_out};
  int miscompares, checked;
  bpio_ctrl #(.STEP_CYC(STEP), .RESET_HOLD_CYC(HOLD), .OUT_MIN_CYC(OUTC), .MON_LINES(15)) bpio_ctrl_i (.*);
  bpio_device_model bpio_device_model_i (.mclk(mclk), .present(present), .word(word),
    .external_data_ready(external_data_ready), .data_in(data_in), .status_in(status_in));
  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic pulse_cmd(input int s);
    cmdv[s] = 1'b1;
    tick();
    cmdv = '0;
  endtask
  // high cycles of one pulse output; a pulse that never ends stops the run
  task automatic measure(input int s, output int n);
    n = 0;
    for (int i = 0; i < 40000; i++) begin
      if (outs[s] === 1'b1) n++;
      else if (n > 0) return;
      tick();
    end
    miscompares++;
    tally_and_finish();
  endtask
  task automatic s_reset;
    int n;
    tick(16);
    rstn = 1'b1;
    self_test_ok = 1'b1;
    measure(3, n);
    chk(n >= HOLD && n <= HOLD + 2, 1);
    chk({power_indicator, ready_indicator}, 2'h3);
  endtask
  task automatic s_error;
    cmd_error = 1'b1;
    listener = 1'b1;
    tick();
    cmd_error = 1'b0;
    chk({error_indicator, listen_indicator}, 2'h3);
    listener = 1'b0;
  endtask
  task automatic s_pulses;
    int n;
    int unsigned least [4] = '{bpio_pkg::STROBE_CYC, bpio_pkg::STROBE_CYC, bpio_pkg::STROBE_CYC,
                               bpio_pkg::RESET_PULSE_CYC};
    for (int s = 0; s < 4; s++) begin
      pulse_cmd(s);
      measure(s, n);
      chk(n >= least[s], 1);
    end
    chk(error_indicator, 0);
  endtask
  task automatic s_width;
    int n;
    logic [11:0] st [5] = '{12'h003, 12'h007, 12'h000, 12'hbb9, 12'hbb8};
    logic lk [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    int unsigned ex [6] = '{5, 3, 3, 3, 3, 3000};
    for (int k = 0; k < 6; k++) begin
      pulse_cmd(4);
      measure(4, n);
      chk(n, ex[k] * STEP);
      if (k < 5) begin
        pulse_steps = st[k];
        lock_on = lk[k];
        cmd_setup_write = 1'b1;
        pulse_width_write = 1'b1;
        #1;
        chk({setup_reject, setup_visible}, {lk[k], !lk[k]});
        tick();
        {lock_on, cmd_setup_write, pulse_width_write} = 3'h0;
      end
    end
  endtask
  task automatic s_inhibit;
    word = 48'h0123_4567_89a9;
    present = 1'b1;
    for (int i = 0; i < 200 && data_inhibit !== 1'b1; i++) tick();
    chk(data_inhibit, 1);
    if (data_inhibit !== 1'b1) tally_and_finish();
    talker = 1'b1;
    tick(3);
    chk({data_inhibit, talk_indicator}, 2'h1);
    chk(input_latch, word);
    chk(status_sync, word[1:0]);
    {talker, present} = 2'h0;
  endtask
  task automatic s_output;
    out_word = 48'ha5a5_0f0f_3c3c;
    cmd_terminator = 1'b1;
    tick();
    cmd_terminator = 1'b0;
    tick(OUTC - 3);
    chk(data_out, 48'h0);
    tick(4);
    chk(data_out, out_word);
  endtask
  task automatic s_select;
    {serial_present, bus_present, serial_cmd_valid} = 3'h7;
    for (int u = 0; u < 16; u++) begin
      my_unit_addr = u[3:0];
      serial_unit_addr = {4'h3, u[3:0]};
      tick();
      chk(cmd_accept, 1);
    end
    serial_unit_addr = 8'h31;
    {serial_cmd_valid, bus_cmd_valid} = 2'h1;
    #1;
    chk(cmd_accept, 0);
    tick();
    {bus_cmd_valid, bus_remote} = 2'h1;
    tick(2);
    bus_remote = 1'b0;
    bus_cmd_valid = 1'b1;
    #1;
    chk({serial_selected, cmd_accept}, 2'h1);
    tick();
    bus_cmd_valid = 1'b0;
  endtask
  task automatic s_addr;
    {primary_addr, rx_primary} = {5'h05, 5'h05};
    tick();
    chk(addr_match, 1);
    rx_primary = 5'h06;
    tick();
    chk(addr_match, 0);
    {primary_addr, rx_primary} = {5'h1f, 5'h1f};
    tick();
    chk(addr_match, 0);
    {primary_addr, rx_primary, rx_sec_valid, rx_secondary} = {5'h05, 5'h05, 1'b1, 5'h01};
    addr_mode = bpio_pkg::BPIO_ADDR_SEC;
    tick();
    chk({addr_match, addr_upper}, 2'h3);
    addr_mode = bpio_pkg::BPIO_ADDR_DUAL;
    {rx_primary, rx_sec_valid} = {5'h06, 1'b0};
    tick();
    chk({addr_match, addr_upper}, 2'h3);
  endtask
  task automatic s_srq;
    {srq_enable, event_status_pending} = 2'h3;
    tick(2);
    chk({srq_out, srq_indicator}, 2'h3);
    talker = 1'b1;
    tick(2);
    chk(srq_out, 0);
    {talker, event_status_pending, monitor_mask} = {2'h0, 15'h7fff};
    monitor_in[2] = 1'b1;
    tick(6);
    chk({questionable_reg[2], srq_out}, 2'h3);
    questionable_clear = 1'b1;
    tick();
    questionable_clear = 1'b0;
    tick(2);
    chk(questionable_reg, 15'h0);
  endtask
  // main sequence
  initial begin
    {rstn, serial_present, bus_present, bus_remote, serial_cmd_valid, bus_cmd_valid, rx_sec_valid} = '0;
    {cmd_terminator, cmd_error, cmd_setup_write, pulse_width_write, lock_on, talker, listener} = '0;
    {srq_enable, event_status_pending, self_test_ok, questionable_clear, present, cmdv} = '0;
    {serial_unit_addr, my_unit_addr, primary_addr, rx_primary, rx_secondary, pulse_steps} = '0;
    {monitor_in, monitor_mask, out_word, word} = '0;
    addr_mode = bpio_pkg::BPIO_ADDR_SINGLE;
    s_reset();
    s_error();
    s_pulses();
    s_width();
    s_inhibit();
    s_output();
    s_select();
    s_addr();
    s_srq();
    tally_and_finish();
  end
endmodule
`default_nettype wire
